// file: verilog/rsu_user.sv
// User controller of the remote upgrade circuitry, AHB-Lite registers
// Operation
// RULE1 - Power-up loads boot image at fixed address
// RULE2 - Circuitry records the reconfiguration cause
// RULE3 - Any application error falls back to boot
// RULE4 - Boot image reads status cause first
// RULE5 - Boot image programs parameters then reconfigures
// RULE6 - Application triggers reload into boot image
// RULE7 - Boot image writes next boot address
// RULE8 - Boot image writes early done check enable
// RULE9 - Boot image writes watchdog enable and time-out
// RULE10 - Boot image reports decoded fallback cause
// RULE11 - Application reads back address, watchdog, triggers
// RULE12 - Reconfiguration trigger delayed by fixed count
// RULE13 - Time-out counted in watchdog clock cycles
// RULE14 - Application kicks watchdog every fixed period
// RULE15 - Kick pulse lasts at least 250 ns
// RULE16 - Watchdog acts only in application image
// RULE17 - Time-out programmed only from boot image
// RULE18 - Watchdog expiry records cause, reloads boot
// RULE19 - Circuitry holds busy during each access
// RULE20 - Start launches parameter write/read sequence
// RULE21 - Selector and data held until busy falls
//
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "rsu_defs.svh"
module rsu_user
	import rsu_pkg::*;
#(
	parameter int unsigned KICK_PERIOD = `RSU_KICK_PERIOD,
	parameter int unsigned KICK_PULSE  = `RSU_KICK_PULSE_CYC
) (
	input  wire logic        core_clk,  // Core clock
	input  wire logic        rst,       // Synchronous reset
	rsu_if.user              ru,        // Link to the circuitry
	input  wire logic        hsel,      // AHB slave select
	input  wire logic [31:0] haddr,     // AHB address
	input  wire logic [1:0]  htrans,    // AHB transfer type
	input  wire logic        hwrite,    // AHB write
	input  wire logic [2:0]  hsize,     // AHB size, word only
	input  wire logic [31:0] hwdata,    // AHB write data
	input  wire logic        hready,    // AHB bus ready
	output logic             hreadyout, // AHB slave ready
	output logic [31:0]      hrdata,    // AHB read data
	output logic             hresp      // AHB response, always OKAY
);
	rsu_usr_t r;
	rsu_usr_t n;
	logic start;
	logic trig;
	logic last;
	logic [3:0] op;
	logic [3:0] op_n;

	// Step table: {write, selector} for each image
	function automatic logic [3:0] step_op(input logic app, input logic [2:0] s);
		logic [3:0] o;
		o = {1'b0, `RSU_P_STATUS}; // RULE4
		if (app) begin
			case (s)
				3'h0: o = {1'b0, `RSU_P_BOOT_ADDR}; // RULE11
				3'h1: o = {1'b0, `RSU_P_WD_EN}; // RULE11
				default: o = {1'b0, `RSU_P_WD_VALUE}; // RULE11
			endcase
		end else begin
			case (s)
				3'h0: o = {1'b0, `RSU_P_STATUS}; // RULE4
				3'h1: o = {1'b1, `RSU_P_BOOT_ADDR}; // RULE7
				3'h2: o = {1'b1, `RSU_P_EARLY_CD}; // RULE8
				3'h3: o = {1'b1, `RSU_P_WD_EN}; // RULE9
				default: o = {1'b1, `RSU_P_WD_VALUE}; // RULE9 RULE17
			endcase
		end
		return o;
	endfunction

	// Next state
	always_comb begin
		n = r;
		start = 1'b0;
		trig = 1'b0;
		op = step_op(ru.app_mode, r.step);
		op_n = step_op(ru.app_mode, r.step + 3'h1);
		last = ru.app_mode ? (r.step == 3'h2) : (r.step == 3'h4);
		n.hresp = 1'b0;
		// Bus slave: one wait state on every transfer
		if (r.dph) begin
			n.dph = 1'b0;
			n.hreadyout = 1'b1;
			if (r.dph_wr) begin
				case (r.dph_idx)
					`RSU_R_CTRL: begin
						start = hwdata[`RSU_CTRL_START]; // RULE20
						trig = hwdata[`RSU_CTRL_TRIG]; // RULE6
					end
					`RSU_R_CONFIG: begin
						n.early_cd = hwdata[`RSU_CFG_CD];
						n.wd_en = hwdata[`RSU_CFG_WDEN];
						n.kick_en = hwdata[`RSU_CFG_KICK];
					end
					`RSU_R_BOOT: n.boot_addr = hwdata[23:0];
					`RSU_R_WDVAL: n.wd_value = hwdata;
					default: n.boot_addr = r.boot_addr;
				endcase
			end else begin
				n.hrdata = 32'h0;
				case (r.dph_idx)
					`RSU_R_CTRL: begin
						n.hrdata[`RSU_ST_BUSY] = (r.st != RSU_S_IDLE);
						n.hrdata[`RSU_ST_APP] = ru.app_mode;
						n.hrdata[`RSU_ST_DONE] = r.done;
					end
					`RSU_R_CONFIG: n.hrdata[2:0] = {r.kick_en, r.wd_en, r.early_cd};
					`RSU_R_BOOT: n.hrdata = {8'h00, r.boot_addr};
					`RSU_R_WDVAL: n.hrdata = r.wd_value;
					`RSU_R_CAUSE: n.hrdata = {27'h0, r.cause}; // RULE10
					`RSU_R_RB_ADDR: n.hrdata = {8'h00, r.rb_addr};
					`RSU_R_RB_WDVAL: n.hrdata = r.rb_wd_value;
					`RSU_R_RB_WDEN: n.hrdata = {31'h0, r.rb_wd_en};
					default: n.hrdata = 32'h0;
				endcase
			end
		end else if (hsel && htrans[1] && hready) begin
			n.dph = 1'b1;
			n.dph_wr = hwrite && (haddr[31:8] == 24'h0);
			n.dph_idx = (haddr[31:8] == 24'h0) ? haddr[7:2] : 6'h3f;
			n.hreadyout = 1'b0;
		end
		// Parameter sequencer
		n.reconfig = 1'b0;
		case (r.st)
			RSU_S_IDLE: begin
				if (trig) begin
					n.done = 1'b0;
					n.st = RSU_S_TRIG; // RULE6 RULE11
				end else if (start) begin
					n.done = 1'b0;
					n.step = 3'h0;
					n.st = RSU_S_ISSUE; // RULE20
				end
			end
			RSU_S_ISSUE: begin
				n.param = op[2:0];
				n.wr = op[3];
				n.rd = !op[3];
				case (op[2:0])
					`RSU_P_BOOT_ADDR: n.wdata = {8'h00, r.boot_addr}; // RULE7
					`RSU_P_EARLY_CD: n.wdata = {31'h0, r.early_cd}; // RULE8
					`RSU_P_WD_EN: n.wdata = {31'h0, r.wd_en}; // RULE9
					`RSU_P_WD_VALUE: n.wdata = r.wd_value; // RULE9
					default: n.wdata = 32'h0;
				endcase
				n.st = RSU_S_WAIT;
			end
			RSU_S_WAIT: begin
				n.rd = 1'b0;
				n.wr = 1'b0;
				// Selector and data stay put until busy falls
				if (!r.rd && !r.wr && !ru.busy) begin // RULE21
					if (!op[3]) begin
						case (op[2:0])
							`RSU_P_STATUS: n.cause = ru.rdata[4:0]; // RULE4 RULE10
							`RSU_P_BOOT_ADDR: n.rb_addr = ru.rdata[23:0];
							`RSU_P_WD_EN: n.rb_wd_en = ru.rdata[0];
							`RSU_P_WD_VALUE: n.rb_wd_value = ru.rdata;
							default: n.cause = r.cause;
						endcase
					end
					if (!last) begin
						n.step = r.step + 3'h1;
						n.param = op_n[2:0];
						n.st = RSU_S_ISSUE;
					end else if (ru.app_mode) begin
						n.done = 1'b1;
						n.st = RSU_S_IDLE;
					end else begin
						n.st = RSU_S_TRIG; // RULE5
					end
				end
			end
			RSU_S_TRIG: begin
				n.reconfig = 1'b1; // RULE5 RULE6
				n.done = 1'b1;
				n.st = RSU_S_IDLE;
			end
			default: n.st = RSU_S_IDLE;
		endcase
		// Watchdog kick in the application image
		if (r.pulse_cnt != 8'h00) begin
			n.pulse_cnt = r.pulse_cnt - 8'h01;
		end else begin
			n.reset_timer = 1'b0;
		end
		if (ru.app_mode && r.kick_en) begin
			if (r.kick_cnt == 26'h0) begin
				n.kick_cnt = 26'(KICK_PERIOD - 1); // RULE14
				n.pulse_cnt = 8'(KICK_PULSE - 1); // RULE15
				n.reset_timer = 1'b1; // RULE14
			end else begin
				n.kick_cnt = r.kick_cnt - 26'h1;
			end
		end else begin
			n.kick_cnt = 26'h0;
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r <= '0;
			r.st <= RSU_S_IDLE;
			r.hreadyout <= 1'b1;
			r.boot_addr <= `RSU_FACTORY_ADDR;
			r.wd_value <= `RSU_WD_TIMEOUT;
		end else begin
			r <= n;
		end
	end

	assign ru.param = r.param;
	assign ru.wdata = r.wdata;
	assign ru.rd = r.rd;
	assign ru.wr = r.wr;
	assign ru.reconfig = r.reconfig;
	assign ru.reset_timer = r.reset_timer;
	assign hreadyout = r.hreadyout;
	assign hrdata = r.hrdata;
	assign hresp = r.hresp;
endmodule
`default_nettype wire

// file: verilog/rsu_defs.svh
// Constants shared by the upgrade circuitry and its user controller
`ifndef RSU_DEFS_SVH
`define RSU_DEFS_SVH
// Boot image word address loaded at power-up
`define RSU_FACTORY_ADDR 24'h010000
// Core clock and internal watchdog clock
`define RSU_CLK_NS 10
`define RSU_CORE_MHZ 100
`define RSU_WD_MHZ 10
`define RSU_WD_DIV (`RSU_CORE_MHZ / `RSU_WD_MHZ)
// Watchdog time-out reset value, in watchdog clock cycles
`define RSU_WD_TIMEOUT 32'h0270_0008
// Trigger delay and kick period, in core clock cycles
`define RSU_RECONFIG_DELAY 33554431
`define RSU_KICK_PERIOD 33554432
// Least kick pulse width
`define RSU_KICK_PULSE_NS 250
`define RSU_KICK_PULSE_CYC ((`RSU_KICK_PULSE_NS + `RSU_CLK_NS - 1) / `RSU_CLK_NS)
// Parameter access time of the circuitry
`define RSU_BUSY_CYC 4
// Parameter selector codes
`define RSU_P_STATUS 3'h0
`define RSU_P_EARLY_CD 3'h1
`define RSU_P_WD_VALUE 3'h2
`define RSU_P_WD_EN 3'h3
`define RSU_P_BOOT_ADDR 3'h4
// Cause bit positions in the status word
`define RSU_C_CORE 0
`define RSU_C_CRC 1
`define RSU_C_STATUS 2
`define RSU_C_WD 3
`define RSU_C_EXT 4
// Controller register word indices (byte offset = 4 * index)
`define RSU_R_CTRL 6'h00
`define RSU_R_CONFIG 6'h01
`define RSU_R_BOOT 6'h02
`define RSU_R_WDVAL 6'h03
`define RSU_R_CAUSE 6'h04
`define RSU_R_RB_ADDR 6'h05
`define RSU_R_RB_WDVAL 6'h06
`define RSU_R_RB_WDEN 6'h07
// Field positions
`define RSU_CTRL_START 0
`define RSU_CTRL_TRIG 1
`define RSU_ST_BUSY 0
`define RSU_ST_APP 1
`define RSU_ST_DONE 2
`define RSU_CFG_CD 0
`define RSU_CFG_WDEN 1
`define RSU_CFG_KICK 2
`endif

// file: verilog/rsu_pkg.sv
// Types of the upgrade circuitry and its user controller
package rsu_pkg;
	// Controller sequencer states
	typedef enum logic [1:0] {RSU_S_IDLE, RSU_S_ISSUE, RSU_S_WAIT, RSU_S_TRIG} rsu_seq_t;
	// Circuitry state
	typedef struct packed {
		logic [2:0]  pin_s1;
		logic [2:0]  pin_s2;
		logic        app_mode;
		logic [23:0] cur_addr;
		logic [23:0] boot_addr;
		logic        early_cd;
		logic        wd_en;
		logic [31:0] wd_value;
		logic [31:0] wd_cnt;
		logic [7:0]  wd_pre;
		logic [4:0]  cause;
		logic        pend;
		logic [25:0] dly_cnt;
		logic [7:0]  busy_cnt;
		logic        busy;
		logic [31:0] rdata;
	} rsu_dev_t;
	// Controller state
	typedef struct packed {
		rsu_seq_t    st;
		logic [2:0]  step;
		logic        dph;
		logic        dph_wr;
		logic [5:0]  dph_idx;
		logic        hreadyout;
		logic [31:0] hrdata;
		logic        hresp;
		logic [2:0]  param;
		logic [31:0] wdata;
		logic        rd;
		logic        wr;
		logic        reconfig;
		logic        reset_timer;
		logic [23:0] boot_addr;
		logic        early_cd;
		logic        wd_en;
		logic        kick_en;
		logic [31:0] wd_value;
		logic [4:0]  cause;
		logic [23:0] rb_addr;
		logic        rb_wd_en;
		logic [31:0] rb_wd_value;
		logic        done;
		logic [25:0] kick_cnt;
		logic [7:0]  pulse_cnt;
	} rsu_usr_t;
endpackage

// file: verilog/rsu_if.sv
// Link between the upgrade circuitry and its user controller
`timescale 1ns/1ps
`default_nettype none
interface rsu_if;
	logic [2:0]  param;       // Parameter selector
	logic [31:0] wdata;       // Parameter write data
	logic [31:0] rdata;       // Parameter read data
	logic        rd;          // Read request pulse
	logic        wr;          // Write request pulse
	logic        busy;        // Access in progress
	logic        reconfig;    // Reconfiguration trigger pulse
	logic        reset_timer; // Watchdog kick
	logic        app_mode;    // Application image running
	modport circuit (input param, wdata, rd, wr, reconfig, reset_timer, output rdata, busy, app_mode);
	modport user (output param, wdata, rd, wr, reconfig, reset_timer, input rdata, busy, app_mode);
endinterface
`default_nettype wire

// file: verilog/rsu_circuit.sv
// Remote upgrade circuitry: parameters, watchdog, fallback and reload
`timescale 1ns/1ps
`default_nettype none
`include "rsu_defs.svh"
module rsu_circuit
	import rsu_pkg::*;
#(
	parameter int unsigned RECONFIG_DELAY = `RSU_RECONFIG_DELAY,
	parameter int unsigned WD_DIV         = `RSU_WD_DIV,
	parameter int unsigned BUSY_CYC       = `RSU_BUSY_CYC
) (
	input  wire logic        core_clk,                    // Core clock
	input  wire logic        rst,                         // Synchronous reset, power-up
	rsu_if.circuit           ru,                          // Link to user logic
	input  wire logic        status_error_pin_n,          // External status error, low
	input  wire logic        external_config_reset_pin_n, // External config reset, low
	input  wire logic        crc_error,                   // Configuration CRC error
	output logic [23:0]      cfg_addr,                    // Image address now loaded
	output logic [4:0]       cfg_cause                    // Last reconfiguration cause
);
	rsu_dev_t r;
	rsu_dev_t n;
	logic core_evt;
	logic wd_evt;
	logic wd_tick;
	logic ext_evt;
	logic stat_evt;
	logic crc_evt;

	// Next state
	always_comb begin
		n = r;
		core_evt = 1'b0;
		wd_evt = 1'b0;
		// Pins pass two flops before use
		n.pin_s1 = {crc_error, external_config_reset_pin_n, status_error_pin_n};
		n.pin_s2 = r.pin_s1;
		ext_evt = !r.pin_s2[1];
		stat_evt = !r.pin_s2[0];
		crc_evt = r.pin_s2[2];
		// Parameter access, busy while it runs
		if (r.busy) begin
			if (r.busy_cnt == 8'h00) begin
				n.busy = 1'b0; // RULE19
			end else begin
				n.busy_cnt = r.busy_cnt - 8'h01;
			end
		end else if (ru.rd || ru.wr) begin
			n.busy = 1'b1; // RULE19
			n.busy_cnt = 8'(BUSY_CYC - 1);
			if (ru.wr && !r.app_mode) begin
				case (ru.param)
					`RSU_P_BOOT_ADDR: n.boot_addr = ru.wdata[23:0];
					`RSU_P_EARLY_CD: n.early_cd = ru.wdata[0];
					`RSU_P_WD_EN: n.wd_en = ru.wdata[0];
					`RSU_P_WD_VALUE: n.wd_value = ru.wdata; // RULE13
					default: n.boot_addr = r.boot_addr;
				endcase
			end
			if (ru.rd) begin
				case (ru.param)
					`RSU_P_STATUS: n.rdata = {27'h0, r.cause}; // RULE2
					`RSU_P_BOOT_ADDR: n.rdata = {8'h00, r.app_mode ? r.cur_addr : r.boot_addr};
					`RSU_P_EARLY_CD: n.rdata = {31'h0, r.early_cd};
					`RSU_P_WD_EN: n.rdata = {31'h0, r.wd_en};
					`RSU_P_WD_VALUE: n.rdata = r.wd_value;
					default: n.rdata = 32'h0;
				endcase
			end
		end
		// Trigger held off by a fixed count
		if (r.pend) begin
			if (r.dly_cnt == 26'h0) begin
				core_evt = 1'b1; // RULE12
				n.pend = 1'b0;
			end else begin
				n.dly_cnt = r.dly_cnt - 26'h1;
			end
		end else if (ru.reconfig) begin
			if (RECONFIG_DELAY == 0) begin
				core_evt = 1'b1; // RULE12
			end else begin
				n.pend = 1'b1;
				n.dly_cnt = 26'(RECONFIG_DELAY - 1);
			end
		end
		// Watchdog runs only in the application image
		wd_tick = (r.wd_pre == 8'h00);
		if (r.app_mode && r.wd_en) begin // RULE16
			n.wd_pre = wd_tick ? 8'(WD_DIV - 1) : r.wd_pre - 8'h01;
			if (ru.reset_timer) begin
				n.wd_cnt = 32'h0;
			end else if (wd_tick) begin
				n.wd_cnt = r.wd_cnt + 32'h1; // RULE13
			end
			wd_evt = (r.wd_cnt >= r.wd_value); // RULE18
		end else begin
			n.wd_pre = 8'(WD_DIV - 1);
			n.wd_cnt = 32'h0;
		end
		// Fallback to the boot image, cause recorded by priority
		if (ext_evt || (r.app_mode && (stat_evt || crc_evt || wd_evt || core_evt))) begin
			n.app_mode = 1'b0; // RULE3
			n.cur_addr = `RSU_FACTORY_ADDR;
			n.pend = 1'b0;
			n.busy = 1'b0;
			n.cause = 5'h0;
			if (ext_evt) begin
				n.cause[`RSU_C_EXT] = 1'b1; // RULE2
			end else if (stat_evt) begin
				n.cause[`RSU_C_STATUS] = 1'b1; // RULE2
			end else if (crc_evt) begin
				n.cause[`RSU_C_CRC] = 1'b1; // RULE2
			end else if (wd_evt) begin
				n.cause[`RSU_C_WD] = 1'b1; // RULE18
			end else begin
				n.cause[`RSU_C_CORE] = 1'b1; // RULE2
			end
		end else if (core_evt) begin
			// Load the application image unless its load fails
			n.busy = 1'b0;
			if (crc_evt) begin
				n.cause = 5'h0;
				n.cause[`RSU_C_CRC] = 1'b1; // RULE3
			end else begin
				n.app_mode = 1'b1;
				n.cur_addr = r.boot_addr;
				n.wd_cnt = 32'h0;
			end
		end
	end

	// State register, power-up loads the boot image
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r <= '0;
			r.pin_s1 <= 3'h3;
			r.pin_s2 <= 3'h3;
			r.cur_addr <= `RSU_FACTORY_ADDR; // RULE1
			r.boot_addr <= `RSU_FACTORY_ADDR;
			r.wd_value <= `RSU_WD_TIMEOUT;
		end else begin
			r <= n;
		end
	end

	assign ru.rdata = r.rdata;
	assign ru.busy = r.busy;
	assign ru.app_mode = r.app_mode;
	assign cfg_addr = r.cur_addr;
	assign cfg_cause = r.cause;
endmodule
`default_nettype wire

// file: bench/rsu_props.sv
// Assertions on the link between the upgrade circuitry and its controller
`timescale 1ns/1ps
`default_nettype none
module rsu_props #(
	parameter int KICK_PERIOD    = 200,
	parameter int KICK_PULSE     = 25,
	parameter int RECONFIG_DELAY = 20
) (
	input wire logic        core_clk,    // Core clock
	input wire logic        rst,         // Synchronous reset
	input wire logic [2:0]  param,       // Parameter selector
	input wire logic [31:0] wdata,       // Parameter write data
	input wire logic        rd,          // Read request
	input wire logic        wr,          // Write request
	input wire logic        busy,        // Access in progress
	input wire logic        reconfig,    // Reload trigger
	input wire logic        reset_timer, // Watchdog kick
	input wire logic        app_mode     // Application running
);
	localparam int DLO = RECONFIG_DELAY - 1;
	localparam int DHI = RECONFIG_DELAY + 3;
	logic [31:0] run_cnt;
	logic [31:0] gap_cnt;
	logic        kicked;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Length of each kick and distance between kick starts
	always_ff @(posedge core_clk) begin
		if (rst) begin
			run_cnt <= '0;
			gap_cnt <= '0;
			kicked  <= 1'b0;
		end else begin
			run_cnt <= reset_timer ? run_cnt + 32'h1 : 32'h0;
			gap_cnt <= (reset_timer && run_cnt == 0) ? 32'h1 : gap_cnt + 32'h1;
			kicked  <= kicked | reset_timer;
		end
	end
	property p_busy_start;
		(rd || wr) && !busy |=> busy;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy did not rise after request");
	property p_busy_len;
		$rose(busy) |-> busy[*4] ##1 !busy;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_sel_hold;
		busy |-> $stable(param) && $stable(wdata);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selector or data moved while busy");
	property p_req_idle;
		(rd || wr) |-> !busy && !(rd && wr);
	endproperty
	a_req_idle: assert property (p_req_idle) else $error("request while busy");
	property p_one_pulse;
		(rd || wr || reconfig) |=> !(rd || wr || reconfig);
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("request longer than one cycle");
	property p_kick_width;
		!reset_timer && run_cnt != 0 |-> run_cnt >= KICK_PULSE;
	endproperty
	a_kick_width: assert property (p_kick_width) else $error("kick pulse too short");
	property p_kick_gap;
		reset_timer && run_cnt == 0 && kicked |-> gap_cnt >= KICK_PERIOD - 1;
	endproperty
	a_kick_gap: assert property (p_kick_gap) else $error("kicks too close");
	property p_hold;
		reconfig |=> $stable(app_mode)[*8];
	endproperty
	a_hold: assert property (p_hold) else $error("reload not held off");
	property p_fallback;
		reconfig && app_mode |-> ##[DLO:DHI] !app_mode;
	endproperty
	a_fallback: assert property (p_fallback) else $error("no reload into boot image");
	c_boot_trig: cover property (reconfig && !app_mode);
	c_app_trig: cover property (reconfig && app_mode);
	c_kick: cover property (reset_timer && run_cnt == 0 && kicked);
endmodule
`default_nettype wire

// file: bench/tb.sv
// Testbench joining the upgrade circuitry and its controller
`timescale 1ns/1ps
`default_nettype none
`include "rsu_defs.svh"
module tb;
	logic        core_clk  = 1'b0;
	logic        rst       = 1'b1;
	logic        hsel      = 1'b0;
	logic [31:0] haddr     = '0;
	logic [1:0]  htrans    = '0;
	logic        hwrite    = 1'b0;
	logic [2:0]  hsize     = 3'h2;
	logic [31:0] hwdata    = '0;
	logic        stat_n    = 1'b1;
	logic        ext_n     = 1'b1;
	logic        crc       = 1'b0;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic [23:0] cfg_addr;
	logic [4:0]  cfg_cause;
	logic [31:0] q;
	int          err_total = 0;
	int          tests_run = 0;
	int          cyc       = 0;
	rsu_if rif ();
	rsu_circuit #(.RECONFIG_DELAY(20)) u_rsu_circuit (
		.core_clk(core_clk), .rst(rst), .ru(rif), .status_error_pin_n(stat_n),
		.external_config_reset_pin_n(ext_n), .crc_error(crc), .cfg_addr(cfg_addr), .cfg_cause(cfg_cause));
	rsu_user #(.KICK_PERIOD(200), .KICK_PULSE(25)) u_rsu_user (
		.core_clk(core_clk), .rst(rst), .ru(rif), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp));
	rsu_props u_rsu_props (
		.core_clk(core_clk), .rst(rst), .param(rif.param), .wdata(rif.wdata), .rd(rif.rd), .wr(rif.wr),
		.busy(rif.busy), .reconfig(rif.reconfig), .reset_timer(rif.reset_timer), .app_mode(rif.app_mode));
	// Clock and hang guard
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			test_done();
		end
	end
	function automatic logic [31:0] ra(input logic [5:0] idx);
		return {24'h0, idx, 2'h0};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One single word transfer, address phase then data phase
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		hsize  <= 3'h2;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		r = hrdata;
	endtask
	task automatic wr_reg(input logic [5:0] idx, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, ra(idx), d, r);
	endtask
	task automatic rd_chk(input string nm, input logic [5:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, ra(idx), 32'h0, r);
		chk(nm, r, exp);
	endtask
	// Poll the sequencer until idle
	task automatic idle_wait();
		int n;
		for (n = 0; n < 60; n++) begin
			xfer(1'b0, ra(`RSU_R_CTRL), 32'h0, q);
			if (q[0] === 1'b0) break;
		end
	endtask
	task automatic wait_app(input logic v);
		int n;
		for (n = 0; n < 600 && rif.app_mode !== v; n++) @(posedge core_clk);
		chk("app_mode", {31'h0, rif.app_mode}, {31'h0, v});
	endtask
	// Main sequence
	initial begin
		int i;
		logic [4:0] prev;
		logic [4:0] bitv;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk("cfg_addr", {8'h0, cfg_addr}, 32'h0001_0000);
		rd_chk("config", `RSU_R_CONFIG, 32'h0);
		rd_chk("boot", `RSU_R_BOOT, 32'h0001_0000);
		rd_chk("wdval", `RSU_R_WDVAL, 32'd40894472);
		xfer(1'b1, 32'h100, 32'hffff_ffff, q);
		xfer(1'b0, 32'h100, 32'h0, q);
		chk("unmapped", q, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
		prev = 5'h0;
		for (i = 0; i < 4; i++) begin
			wr_reg(`RSU_R_BOOT, 32'h20_0000 + i);
			wr_reg(`RSU_R_CONFIG, 32'h7);
			wr_reg(`RSU_R_WDVAL, 32'd30);
			wr_reg(`RSU_R_CTRL, 32'h1);
			wait_app(1'b1);
			rd_chk("cause", `RSU_R_CAUSE, {27'h0, prev});
			chk("cfg_addr", {8'h0, cfg_addr}, 32'h20_0000 + i);
			wr_reg(`RSU_R_CTRL, 32'h1);
			idle_wait();
			chk("ctrl", q, 32'h6);
			rd_chk("rb_addr", `RSU_R_RB_ADDR, 32'h20_0000 + i);
			rd_chk("rb_wdval", `RSU_R_RB_WDVAL, 32'd30);
			rd_chk("rb_wden", `RSU_R_RB_WDEN, 32'h1);
			// Over two time-outs long: kicks keep the image alive
			repeat (700) @(posedge core_clk);
			chk("kept", {31'h0, rif.app_mode}, 32'h1);
			case (i)
				0: begin
					wr_reg(`RSU_R_CONFIG, 32'h3);
					bitv = 5'h08;
				end
				1: begin
					stat_n <= 1'b0;
					repeat (6) @(posedge core_clk);
					stat_n <= 1'b1;
					bitv = 5'h04;
				end
				2: begin
					ext_n <= 1'b0;
					repeat (6) @(posedge core_clk);
					ext_n <= 1'b1;
					bitv = 5'h10;
				end
				default: begin
					wr_reg(`RSU_R_CTRL, 32'h2);
					bitv = 5'h01;
				end
			endcase
			wait_app(1'b0);
			chk("cfg_cause", {27'h0, cfg_cause}, {27'h0, bitv});
			chk("cfg_addr", {8'h0, cfg_addr}, 32'h0001_0000);
			prev = bitv;
		end
		// Load error while entering the application image
		crc <= 1'b1;
		wr_reg(`RSU_R_CTRL, 32'h1);
		idle_wait();
		repeat (30) @(posedge core_clk);
		chk("crc_app", {31'h0, rif.app_mode}, 32'h0);
		chk("crc_cause", {27'h0, cfg_cause}, 32'h2);
		crc <= 1'b0;
		wr_reg(`RSU_R_CTRL, 32'h1);
		wait_app(1'b1);
		rd_chk("cause", `RSU_R_CAUSE, 32'h2);
		test_done();
	end
endmodule
`default_nettype wire
